// *** rtl/rx_address_pattern_filter.v ***
// Receive address and pattern filter with AXI4-Lite register access
// Behaviour
// - Data port carries 16 data bits low and two byte-mask bits 17-16 above.
// - Internal address comes from control register low field; data port does access.
// - Exact address register reachable as words at 000h, 002h, 004h.
// - Octet 0 matches first destination octet; lower octet in low byte.
// - With exact match enabled, equal destination address accepts the packet.
// - Accept-all broadcast, multicast and unicast each have an enable bit.
// - Four pattern buffers; 0 and 1 span 64 bytes, 2 and 3 span 128.
// - Any enabled buffer match accepts; disabled buffers are ignored.
// - Pattern word is 18 bits: two bytes, byte 0 mask bit 16, byte 1 bit 17.
// - Compare byte by byte for programmed count; masked bytes always match.
// - Counts at 0006 (count 0 low, count 1 high) and 0008 (2 low, 3 high).
// - Pattern memory 100h words; buffers at 280+4n/282+4n and 300+4n/302+4n.
// - Pattern memory uses the same indirect address-then-data-port access.
// - Four pattern-enable bits in control register select participating buffers.
// - Local-bit ignore masks bit 1 (second LSb) of the first destination octet in exact comparison.
`timescale 1ns/1ps
`include "rx_filter_regs.vh"
module rx_address_pattern_filter (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_first,
  input wire rx_last,
  output reg rx_accept,
  output reg rx_reject
);

////////////////////////////////////////////////////////////////////////////////
// Storage
reg [31:0] filter_control_reg;
reg [47:0] exact_address_reg;
reg [31:0] pattern_length_reg;
reg [17:0] pattern_mem [0:`MEM_WORDS-1];
reg [17:0] filter_data_port_reg;
reg [7:0] aw_addr_reg;
reg aw_full_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg w_full_reg;
reg [6:0] pos_reg;
reg in_pkt_reg;
reg [3:0] pat_alive_reg;
reg [3:0] pat_hit_reg;
reg exact_ok_reg;
reg bcast_reg;
reg mcast_reg;
reg [3:0] last_result_reg;
reg [6:0] pos_next;
reg [3:0] pat_alive_next;
reg [3:0] pat_hit_next;
reg exact_ok_next;
reg bcast_next;
reg mcast_next;

wire [9:0] int_addr = filter_control_reg[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
wire [7:0] int_idx = int_addr[8:1];

////////////////////////////////////////////////////////////////////////////////
// Helpers
function [7:0] pat_idx;
  input [1:0] buf_sel;
  input [6:0] pos;
  begin
    if (buf_sel[1]) begin
      pat_idx = `MEM_IDX_BUF23 + {1'b0, pos[6:1], 1'b0} + {7'h00, buf_sel[0]};
    end else begin
      pat_idx = `MEM_IDX_BUF01 + {1'b0, pos[6:1], 1'b0} + {7'h00, buf_sel[0]};
    end
  end
endfunction

function [7:0] count_of;
  input [1:0] buf_sel;
  input [31:0] counts;
  begin
    case (buf_sel)
      2'd0: count_of = counts[7:0];
      2'd1: count_of = counts[15:8];
      2'd2: count_of = counts[23:16];
      default: count_of = counts[31:24];
    endcase
  end
endfunction

function [7:0] pick_byte;
  input [47:0] vec;
  input [2:0] sel;
  begin
    pick_byte = vec[{sel, 3'b000} +: 8];
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write path
assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
wire [15:0] wr_field = w_data_reg[`DATA_FIELD_HI:`DATA_FIELD_LO];
wire [1:0] wr_mask = w_data_reg[`DATA_MASK_HI:`DATA_MASK_LO];
wire wr_ctrl = wr_fire && (aw_addr_reg == `CTRL_OFFSET);
wire wr_data = wr_fire && (aw_addr_reg == `DATA_OFFSET);
wire wr_stat = wr_fire && (aw_addr_reg == `STAT_OFFSET);
wire wr_mem = wr_data && (int_addr >= `IA_MEM_BASE);
wire [31:0] ctrl_masked = w_data_reg & `CTRL_WR_MASK;

always @(posedge aclk) begin
  if (!aresetn) begin
    aw_full_reg <= 1'b0;
    w_full_reg <= 1'b0;
    aw_addr_reg <= 8'h00;
    w_data_reg <= 32'h0000_0000;
    w_strb_reg <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
  end else begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_bvalid <= 1'b1;
      if (wr_ctrl || wr_data || wr_stat) begin
        s_axi_bresp <= `RESP_OKAY;
      end else begin
        s_axi_bresp <= `RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Control, exact address, counts and indirect writes
always @(posedge aclk) begin
  if (!aresetn) begin
    filter_control_reg <= `CTRL_RESET;
    exact_address_reg <= 48'h0000_0000_0000;
    pattern_length_reg <= 32'h0000_0000;
  end else if (wr_ctrl) begin
    filter_control_reg <= ctrl_masked;
  end else if (wr_data) begin
    if (int_addr == `IA_EXACT_10) begin
      exact_address_reg[15:0] <= wr_field;
    end else if (int_addr == `IA_EXACT_32) begin
      exact_address_reg[31:16] <= wr_field;
    end else if (int_addr == `IA_EXACT_54) begin
      exact_address_reg[47:32] <= wr_field;
    end else if (int_addr == `IA_COUNT_10) begin
      pattern_length_reg[15:0] <= wr_field;
    end else if (int_addr == `IA_COUNT_32) begin
      pattern_length_reg[31:16] <= wr_field;
    end
  end
end

always @(posedge aclk) begin
  if (wr_mem) begin
    pattern_mem[int_idx] <= {wr_mask, wr_field};
  end
end

////////////////////////////////////////////////////////////////////////////////
// Indirect read view of the addressed location
always @* begin
  if (int_addr == `IA_EXACT_10) begin
    filter_data_port_reg = {2'b00, exact_address_reg[15:0]};
  end else if (int_addr == `IA_EXACT_32) begin
    filter_data_port_reg = {2'b00, exact_address_reg[31:16]};
  end else if (int_addr == `IA_EXACT_54) begin
    filter_data_port_reg = {2'b00, exact_address_reg[47:32]};
  end else if (int_addr == `IA_COUNT_10) begin
    filter_data_port_reg = {2'b00, pattern_length_reg[15:0]};
  end else if (int_addr == `IA_COUNT_32) begin
    filter_data_port_reg = {2'b00, pattern_length_reg[31:16]};
  end else if (int_addr >= `IA_MEM_BASE) begin
    filter_data_port_reg = pattern_mem[int_idx];
  end else begin
    filter_data_port_reg = 18'h0_0000;
  end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read path
assign s_axi_arready = !s_axi_rvalid;
wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
wire [31:0] port_word = {14'h0000, filter_data_port_reg};
wire [31:0] stat_word = {20'h0_0000, pat_hit_reg, 4'h0, last_result_reg};

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `RESP_OKAY;
  end else if (s_axi_arvalid && s_axi_arready) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp <= `RESP_OKAY;
    if (rd_addr == `CTRL_OFFSET) begin
      s_axi_rdata <= filter_control_reg;
    end else if (rd_addr == `DATA_OFFSET) begin
      s_axi_rdata <= port_word;
    end else if (rd_addr == `STAT_OFFSET) begin
      s_axi_rdata <= stat_word;
    end else begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_SLVERR;
    end
  end else if (s_axi_rvalid && s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Packet matching
wire [6:0] pos_now = rx_first ? 7'h00 : pos_reg;
wire [7:0] da_exp = pick_byte(exact_address_reg, pos_now[2:0]);
wire local_ign = filter_control_reg[`CTRL_LOCAL_BIT];
wire [7:0] da_mask = local_ign && (pos_now == 7'h00) ? ~(8'h01 << `LOCAL_BIT) : 8'hff;
wire da_byte_eq = ((rx_data ^ da_exp) & da_mask) == 8'h00;
wire [3:0] pat_en = filter_control_reg[`CTRL_PAT_HI:`CTRL_PAT_LO];
wire active = rx_first || in_pkt_reg;
integer b;
reg [17:0] pw;
reg [7:0] pcnt;
reg byte_ok;

always @* begin
  pw = 18'h0_0000;
  pcnt = 8'h00;
  byte_ok = 1'b0;
  pos_next = pos_reg;
  exact_ok_next = rx_first ? 1'b1 : exact_ok_reg;
  bcast_next = rx_first ? 1'b1 : bcast_reg;
  mcast_next = mcast_reg;
  pat_alive_next = rx_first ? 4'hf : pat_alive_reg;
  pat_hit_next = rx_first ? 4'h0 : pat_hit_reg;
  if (rx_valid && active) begin
    if (pos_now != `POS_MAX) begin
      pos_next = pos_now + 7'h01;
    end
    if (pos_now <= `DA_LAST) begin
      if (!da_byte_eq) begin
        exact_ok_next = 1'b0;
      end
      if (rx_data != 8'hff) begin
        bcast_next = 1'b0;
      end
      if (pos_now == 7'h00) begin
        mcast_next = rx_data[`GROUP_BIT];
      end
    end
    for (b = 0; b < 4; b = b + 1) begin
      pw = pattern_mem[pat_idx(b[1:0], pos_now)];
      pcnt = count_of(b[1:0], pattern_length_reg);
      if (pos_now[0]) begin
        byte_ok = pw[`DATA_MASK_HI] || (pw[15:8] == rx_data);
      end else begin
        byte_ok = pw[`DATA_MASK_LO] || (pw[7:0] == rx_data);
      end
      if ({1'b0, pos_now} < pcnt) begin
        if (!byte_ok) begin
          pat_alive_next[b] = 1'b0;
        end else if (({1'b0, pos_now} + 8'h01 == pcnt) && pat_alive_next[b]) begin
          pat_hit_next[b] = 1'b1;
        end
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Acceptance decision
wire en = filter_control_reg[`CTRL_EN_BIT];
wire short_da = pos_now < `DA_LAST;
wire ucast = !mcast_next && !short_da;
wire acc_now = en && (
  (filter_control_reg[`CTRL_AAB_BIT] && bcast_next && !short_da) ||
  (filter_control_reg[`CTRL_AAM_BIT] && mcast_next && !bcast_next) ||
  (filter_control_reg[`CTRL_AAU_BIT] && ucast) ||
  (filter_control_reg[`CTRL_APM_BIT] && exact_ok_next && !short_da) ||
  ((pat_hit_next & pat_en) != 4'h0));

always @(posedge aclk) begin
  if (!aresetn) begin
    pos_reg <= 7'h00;
    in_pkt_reg <= 1'b0;
    pat_alive_reg <= 4'h0;
    pat_hit_reg <= 4'h0;
    exact_ok_reg <= 1'b0;
    bcast_reg <= 1'b0;
    mcast_reg <= 1'b0;
    last_result_reg <= 4'h0;
    rx_accept <= 1'b0;
    rx_reject <= 1'b0;
  end else begin
    rx_accept <= 1'b0;
    rx_reject <= 1'b0;
    if (rx_valid && active) begin
      pos_reg <= pos_next;
      pat_alive_reg <= pat_alive_next;
      pat_hit_reg <= pat_hit_next;
      exact_ok_reg <= exact_ok_next;
      bcast_reg <= bcast_next;
      mcast_reg <= mcast_next;
      in_pkt_reg <= !rx_last;
      if (rx_last) begin
        rx_accept <= acc_now;
        rx_reject <= !acc_now;
        last_result_reg <= {exact_ok_next, bcast_next, mcast_next, acc_now};
      end
    end
  end
end

endmodule

// *** rtl/rx_filter_regs.vh ***
// Register offsets, field positions and internal addresses of the receive filter
`ifndef RX_FILTER_REGS_VH
`define RX_FILTER_REGS_VH
`define CTRL_OFFSET 8'h48
`define DATA_OFFSET 8'h4c
`define STAT_OFFSET 8'h60
`define CTRL_RESET 32'h0000_0000
`define DATA_RESET 32'h0000_0000
`define CTRL_EN_BIT 31
`define CTRL_AAB_BIT 30
`define CTRL_AAM_BIT 29
`define CTRL_AAU_BIT 28
`define CTRL_APM_BIT 27
`define CTRL_PAT_HI 26
`define CTRL_PAT_LO 23
`define CTRL_LOCAL_BIT 19
`define CTRL_ADDR_HI 9
`define CTRL_ADDR_LO 0
`define CTRL_WR_MASK 32'hff88_03ff
`define DATA_MASK_HI 17
`define DATA_MASK_LO 16
`define DATA_FIELD_HI 15
`define DATA_FIELD_LO 0
`define IA_EXACT_10 10'h000
`define IA_EXACT_32 10'h002
`define IA_EXACT_54 10'h004
`define IA_COUNT_10 10'h006
`define IA_COUNT_32 10'h008
`define IA_MEM_BASE 10'h200
`define MEM_IDX_BUF01 8'h40
`define MEM_IDX_BUF23 8'h80
`define MEM_WORDS 256
`define DA_LAST 7'h05
`define POS_MAX 7'h7f
`define LOCAL_BIT 1
`define GROUP_BIT 0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** verif/rx_filter_chk.sv ***
// Port checker for the receive address and pattern filter
`timescale 1ns/1ps
module rx_filter_chk (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic rx_valid,
  input logic rx_first,
  input logic rx_last,
  input logic rx_accept,
  input logic rx_reject
);
  logic in_pkt;
  logic [7:0] ar_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////
  // Packet tracking and read address capture
  always @(posedge aclk) begin
    if (!aresetn) in_pkt <= 1'b0;
    else if (rx_valid) in_pkt <= !rx_last && (rx_first || in_pkt);
  end
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  ////////////////////////////////
  sequence s_pkt_end; rx_valid && rx_last && (rx_first || in_pkt); endsequence
  sequence s_wr_go; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd_go; s_axi_arvalid && s_axi_arready; endsequence
  property p_one_verdict; s_pkt_end |=> rx_accept != rx_reject; endproperty
  property p_no_stray; rx_accept || rx_reject |-> $past(rx_valid && rx_last); endproperty
  property p_b_answer; s_wr_go |-> ##[1:2] s_axi_bvalid; endproperty
  property p_b_retire; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_w_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_r_answer; s_rd_go |=> $rose(s_axi_rvalid); endproperty
  property p_r_retire; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_port_bits; s_axi_rvalid && ar_q == 8'h4c |-> s_axi_rdata[31:18] == 14'h0; endproperty
  a_one_verdict: assert property (p_one_verdict) else $error("verdict count");
  a_no_stray: assert property (p_no_stray) else $error("stray verdict");
  a_b_answer: assert property (p_b_answer) else $error("no write answer");
  a_b_retire: assert property (p_b_retire) else $error("bvalid stuck");
  a_w_refuse: assert property (p_w_refuse) else $error("write not refused");
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  a_r_retire: assert property (p_r_retire) else $error("rvalid stuck");
  a_ar_refuse: assert property (p_ar_refuse) else $error("read not refused");
  a_port_bits: assert property (p_port_bits) else $error("data port upper bits");
endmodule
bind rx_address_pattern_filter rx_filter_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_valid(rx_valid),
  .rx_first(rx_first), .rx_last(rx_last), .rx_accept(rx_accept), .rx_reject(rx_reject));

// *** verif/rx_byte_source.sv ***
// Model of the MAC receive byte path
`timescale 1ns/1ps
module rx_byte_source (
  input logic aclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_first,
  output logic rx_last
);
  initial begin
    {rx_valid, rx_first, rx_last} = 3'h0;
    rx_data = 8'h5a;
  end
  // Eight bytes, wire order, idle data toggles between bytes
  task send(input logic [63:0] p, input int gap);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_data <= p[63 - 8 * i -: 8];
      rx_first <= (i == 0);
      rx_last <= (i == 7);
      repeat ((i < 7) ? gap : 0) begin
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
    @(posedge aclk);
    {rx_valid, rx_first, rx_last} <= 3'h0;
    rx_data <= ~rx_data;
  endtask
endmodule

// *** verif/rx_address_pattern_filter_tb.sv ***
// Testbench for the receive address and pattern filter
`timescale 1ns/1ps
`include "rx_filter_regs.vh"
module rx_address_pattern_filter_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, ctrl, rd;
  logic [1:0] resp;
  wire awready, wready, bvalid, arready, rvalid, rx_valid, rx_first, rx_last, rx_accept, rx_reject;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] rx_data;
  int fails, compares, cyc;
  logic [63:0] mp [3];
  ////////////////////////////////
  rx_address_pattern_filter u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last), .rx_accept(rx_accept),
    .rx_reject(rx_reject));
  rx_byte_source u_src (.aclk(aclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      print_verdict();
    end
  end
  ////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task ind_wr(input logic [9:0] ia, input logic [31:0] d);
    axi_wr(`CTRL_OFFSET, ctrl | {22'h0, ia});
    axi_wr(`DATA_OFFSET, d);
  endtask
  task pkt(input logic [63:0] p, input int gap, input logic acc);
    u_src.send(p, gap);
    #1;
    check({30'h0, rx_reject, rx_accept}, acc ? 32'h0000_0001 : 32'h0000_0002);
  endtask
  task print_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////
  task t_reset();
    axi_rd(`DATA_OFFSET);
    check(rd, `DATA_RESET);
    axi_rd(`CTRL_OFFSET);
    check(rd, `CTRL_RESET);
    axi_wr(8'h10, 32'h0000_0001);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    axi_rd(8'h10);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    check(rd, 32'h0000_0000);
    pkt(64'hffff_ffff_ffff_0000, 0, 1'b0);
  endtask
  task t_exact();
    ctrl = 32'h8800_0000;
    ind_wr(10'h000, 32'h0000_0008);
    ind_wr(10'h004, 32'h0000_5528);
    ind_wr(10'h002, 32'h0000_0717);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
    axi_rd(`DATA_OFFSET);
    check(rd, 32'h0000_0717);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
    pkt(64'h0800_1707_2855_aaaa, 0, 1'b1);
    axi_rd(`STAT_OFFSET);
    check(rd, 32'h0000_0009);
    pkt(64'h5528_0717_0008_aaaa, 1, 1'b0);
    pkt(64'h0a00_1707_2855_aaaa, 0, 1'b0);
    ctrl = 32'h8808_0000;
    axi_wr(`CTRL_OFFSET, ctrl);
    axi_rd(`CTRL_OFFSET);
    check(rd, ctrl);
    pkt(64'h0a00_1707_2855_aaaa, 0, 1'b1);
  endtask
  task t_modes();
    mp = '{64'hffff_ffff_ffff_0000, 64'h0100_5e00_0001_0000, 64'h0211_2233_4455_0000};
    for (int i = 0; i < 3; i++) begin
      axi_wr(`CTRL_OFFSET, 32'h8000_0000 | (32'h4000_0000 >> i));
      for (int j = 0; j < 3; j++) pkt(mp[j], 0, i == j);
    end
  endtask
  task t_pattern();
    ctrl = 32'h8000_0000;
    ind_wr(10'h006, 32'h0000_0406);
    ind_wr(10'h008, 32'h0000_0406);
    axi_rd(`DATA_OFFSET);
    check(rd, 32'h0000_0406);
    for (int k = 0; k < 3; k++) begin
      ind_wr(10'h280 + 10'(4 * k), 32'h0000_0002 + 32'(k) * 32'h0000_0101);
      ind_wr(10'h300 + 10'(4 * k), 32'h0000_2022 + 32'(k) * 32'h0000_0101);
    end
    axi_wr(`CTRL_OFFSET, 32'h8080_0000);
    pkt(64'h0200_0301_0402_aaaa, 0, 1'b1);
    pkt(64'h2220_2321_2422_aaaa, 0, 1'b0);
    axi_wr(`CTRL_OFFSET, 32'h8200_0000);
    pkt(64'h0200_0301_0402_aaaa, 0, 1'b0);
    pkt(64'h2220_2321_2422_aaaa, 2, 1'b1);
    ctrl = 32'h8080_0000;
    ind_wr(10'h280, 32'h0003_ffff);
    axi_rd(`DATA_OFFSET);
    check(rd, 32'h0003_ffff);
    pkt(64'h5566_0301_0402_aaaa, 0, 1'b1);
    pkt(64'h5566_0701_0402_aaaa, 0, 1'b0);
  endtask
  ////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, ctrl} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_exact();
    t_modes();
    t_pattern();
    print_verdict();
  end
endmodule
